// ===== bench/dt_pin_model.sv
`timescale 1ns/1ps
module dt_pin_model (
  // Clock.
  input wire logic ref_clk,
  // Pins toward the timers.
  output logic [1:0] countPin,
  output logic [1:0] gatePin
);
  initial begin
    countPin = 2'h3;
    gatePin = 2'h0;
  end
  // Each level is held four cycles, longer than the input synchroniser needs.
  task automatic fall(input int i);
    @(posedge ref_clk);
    countPin <= countPin & ~(2'h1 << i);
    repeat (4) @(posedge ref_clk);
    countPin <= countPin | (2'h1 << i);
    repeat (4) @(posedge ref_clk);
  endtask : fall
  task automatic gate(input int i, input logic v);
    @(posedge ref_clk);
    gatePin <= v ? (gatePin | (2'h1 << i)) : (gatePin & ~(2'h1 << i));
    repeat (4) @(posedge ref_clk);
  endtask : gate
endmodule : dt_pin_model

// ===== bench/dt_top_sva.sv
`timescale 1ns/1ps
module dt_top_sva (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [dt_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  import dt_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_AW_HELD: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("awready high after address taken");
  AST_W_HELD: assert property (s_axi_wvalid && s_axi_wready |=>
    !s_axi_wready) else $error("wready high after data taken");
  AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("bvalid stayed after bready");
  AST_B_CODE: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY
    || s_axi_bresp == RESP_SLVERR) else $error("bad write response");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before rready");
  AST_AR_BLK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready high while read pending");
  AST_R_BYTE: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
endmodule : dt_top_sva
bind dt_top dt_top_sva u_dt_top_sva (.ref_clk(ref_clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp));

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dt_pkg::*;
  logic ref_clk, rst_n, irq;
  logic awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady;
  logic [ADDR_W-1:0] awAddr, arAddr;
  logic [DATA_W-1:0] wData, rData;
  logic [1:0] bResp, rResp, countPin, gatePin;
  logic [7:0] mask, lowA, highA;
  int miscompares = 0;
  int comparisons = 0;

  dt_top u_dt_top (.ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'h1), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_bresp(bResp), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_araddr(arAddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .firstCountPin(countPin[0]), .secondCountPin(countPin[1]),
    .firstExtIrqInput(gatePin[0]), .secondExtIrqInput(gatePin[1]),
    .irq(irq));
  dt_pin_model u_dt_pin_model (.ref_clk(ref_clk), .countPin(countPin),
    .gatePin(gatePin));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
      miscompares++;
    end
  endtask : check

  // A wait that runs out ends the run, since later steps would be meaningless.
  task automatic guard(input int n);
    if (n >= 200) begin
      $display("MISMATCH at %0t: wait 0x%0h of 0x%0h", $time, n, 200);
      miscompares++;
      final_report();
    end
  endtask : guard

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                        input logic [1:0] er);
    int n;
    logic awDone, wDone;
    n = 0;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge ref_clk);
    awAddr <= a;
    wData <= {24'h0, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    do begin
      @(negedge ref_clk);
      if (awValid && awReady) awDone = 1'b1;
      if (wValid && wReady) wDone = 1'b1;
      @(posedge ref_clk);
      if (awDone) awValid <= 1'b0;
      if (wDone) wValid <= 1'b0;
      n++;
    end while (!(awDone && wDone) && n < 200);
    guard(n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!bValid && n < 200);
    guard(n);
    check({30'h0, bResp}, {30'h0, er});
    @(posedge ref_clk);
    bReady <= 1'b1;
    @(posedge ref_clk);
    bReady <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [7:0] e);
    int n;
    logic go;
    n = 0;
    @(posedge ref_clk);
    arAddr <= a;
    arValid <= 1'b1;
    do begin
      @(negedge ref_clk);
      go = arReady;
      @(posedge ref_clk);
      n++;
    end while (!go && n < 200);
    arValid <= 1'b0;
    guard(n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!rValid && n < 200);
    guard(n);
    check(rData, {24'h0, e});
    check({30'h0, rResp}, {30'h0, RESP_OKAY});
    @(posedge ref_clk);
    rReady <= 1'b1;
    @(posedge ref_clk);
    rReady <= 1'b0;
  endtask : axi_rd

  task automatic irq_is(input logic e);
    @(negedge ref_clk);
    check({31'h0, irq}, {31'h0, e});
  endtask : irq_is

  initial begin
    {awValid, wValid, bReady, arValid, rReady} = 5'h0;
    awAddr = 8'h0;
    arAddr = 8'h0;
    wData = 32'h0;
    rst_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    axi_rd(OFF_MODE, 8'h00);
    axi_rd(OFF_STATUS, 8'h00);
    axi_wr(OFF_MODE, 8'hA5, RESP_OKAY);
    axi_rd(OFF_MODE, 8'hA5);
    axi_wr(8'h3C, 8'h55, RESP_SLVERR);
    $display("Register test done");
    axi_wr(OFF_IRQCFG, 8'h03, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      mask = 8'h01 << i;
      lowA = OFF_FIRST_LOW + 8'(8 * i);
      highA = lowA + 8'h04;
      axi_wr(OFF_MODE, 8'h0E << (4 * i), RESP_OKAY);
      axi_wr(lowA, 8'hFE, RESP_OKAY);
      axi_wr(highA, 8'h80, RESP_OKAY);
      axi_wr(OFF_ENABLE, mask, RESP_OKAY);
      axi_wr(OFF_CTRL, mask, RESP_OKAY);
      u_dt_pin_model.fall(i);
      axi_rd(lowA, 8'hFE);
      u_dt_pin_model.gate(i, 1'b1);
      u_dt_pin_model.fall(i);
      axi_rd(lowA, 8'hFF);
      irq_is(1'b0);
      u_dt_pin_model.fall(i);
      axi_rd(lowA, 8'h80);
      axi_rd(highA, 8'h80);
      axi_rd(OFF_STATUS, mask);
      irq_is(1'b1);
      axi_wr(OFF_ENABLE, 8'h00, RESP_OKAY);
      irq_is(1'b0);
      axi_wr(OFF_CLEAR, mask, RESP_OKAY);
      axi_rd(OFF_STATUS, 8'h00);
      u_dt_pin_model.fall(i);
      axi_rd(lowA, 8'h81);
      u_dt_pin_model.gate(i, 1'b0);
      axi_wr(OFF_CTRL, 8'h00, RESP_OKAY);
      $display("Timer %0d test done", i);
    end
    axi_wr(OFF_MODE, 8'h74, RESP_OKAY);
    axi_wr(OFF_FIRST_LOW, 8'h1F, RESP_OKAY);
    axi_wr(OFF_FIRST_HIGH, 8'h07, RESP_OKAY);
    axi_wr(OFF_SECOND_LOW, 8'h44, RESP_OKAY);
    axi_wr(OFF_CTRL, 8'h03, RESP_OKAY);
    u_dt_pin_model.fall(0);
    u_dt_pin_model.fall(1);
    axi_rd(OFF_FIRST_LOW, 8'h00);
    axi_rd(OFF_FIRST_HIGH, 8'h08);
    axi_rd(OFF_SECOND_LOW, 8'h44);
    axi_wr(OFF_CTRL, 8'h00, RESP_OKAY);
    axi_wr(OFF_MODE, 8'h05, RESP_OKAY);
    axi_wr(OFF_FIRST_LOW, 8'hFF, RESP_OKAY);
    axi_wr(OFF_FIRST_HIGH, 8'h12, RESP_OKAY);
    axi_wr(OFF_CTRL, 8'h01, RESP_OKAY);
    u_dt_pin_model.fall(0);
    axi_rd(OFF_FIRST_LOW, 8'h00);
    axi_rd(OFF_FIRST_HIGH, 8'h13);
    axi_rd(OFF_STATUS, 8'h00);
    axi_wr(OFF_CTRL, 8'h00, RESP_OKAY);
    $display("Mode test done");
    final_report();
  end
endmodule : tb_top

// ===== logic/dt_ctl_if.sv
`timescale 1ns/1ps
interface dt_ctl_if;
  logic run;
  logic gateSel;
  logic gateOn;
  logic ctSel;
  logic [1:0] mode;
  logic tick;
  logic pinFall;
  logic splitRun;
  logic wrLow;
  logic wrHigh;
  logic [7:0] wdata;
  logic [7:0] low;
  logic [7:0] high;
  logic ovf;
  logic hiOvf;
  modport unit (
    input run, gateSel, gateOn, ctSel, mode, tick, pinFall, splitRun,
    input wrLow, wrHigh, wdata,
    output low, high, ovf, hiOvf
  );
  modport ctrl (
    output run, gateSel, gateOn, ctSel, mode, tick, pinFall, splitRun,
    output wrLow, wrHigh, wdata,
    input low, high, ovf, hiOvf
  );
endinterface : dt_ctl_if

// ===== logic/dt_pkg.sv
// What this block does
// RULE1 - Reload mode counts low byte, high reloads.
// RULE2 - Low rollover sets flag, reloads from high.
// RULE3 - Flag raises interrupt only when enabled.
// RULE4 - Reload never alters the reload byte.
// RULE5 - Software preloads count before enabling timer.
// RULE6 - Second timer reloads exactly like first.
// RULE7 - Count needs run bit, plus gate level.
// RULE8 - Mode bit 7: second timer gate select.
// RULE9 - Mode bit 6: second timer pin source.
// RULE10 - Bits 5:4: second timer mode select.
// RULE11 - Mode bit 3: first timer gate select.
// RULE12 - Mode bit 2: first timer pin source.
// RULE13 - Bits 1:0: first mode, 11 splits.
// RULE14 - Synchronise pins; falling edge from samples.
// RULE15 - Software byte writes win over reloads.
package dt_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_IRQCFG = 8'h08;
  localparam logic [7:0] OFF_CLKCTL = 8'h0C;
  localparam logic [7:0] OFF_FIRST_LOW = 8'h10;
  localparam logic [7:0] OFF_FIRST_HIGH = 8'h14;
  localparam logic [7:0] OFF_SECOND_LOW = 8'h18;
  localparam logic [7:0] OFF_SECOND_HIGH = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_CLEAR = 8'h24;
  localparam logic [7:0] OFF_ENABLE = 8'h28;
  localparam int SECOND_GATE_SELECT_BIT = 7;
  localparam int CT1_BIT = 6;
  localparam int MODE1_LSB = 4;
  localparam int FIRST_GATE_SELECT_BIT = 3;
  localparam int CT0_BIT = 2;
  localparam int MODE0_LSB = 0;
  localparam int RUN0_BIT = 0;
  localparam int RUN1_BIT = 1;
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [4:0] LOW13_MAX = 5'h1F;
  localparam logic [1:0] FLAG_RESET = 2'h0;
  localparam logic [3:0] PRESC_LAST = 4'hB;
  localparam logic [3:0] PRESC_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dt_pkg

// ===== logic/dt_timer_unit.sv
`timescale 1ns/1ps
module dt_timer_unit #(
  parameter bit CAN_SPLIT = 1'b0
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control and count bytes.
  dt_ctl_if.unit ctl
);
  import dt_pkg::*;

  logic [7:0] next_low;
  logic [7:0] next_high;
  logic next_ovf;
  logic next_hiOvf;
  logic step;

  always_comb begin
    next_low = ctl.low;
    next_high = ctl.high;
    next_ovf = 1'b0;
    next_hiOvf = 1'b0;
    // A pin event counts only while run and gate allow it.
    step = ctl.run && (!ctl.gateSel || ctl.gateOn) &&
      (ctl.ctSel ? ctl.pinFall : ctl.tick); // see RULE7
    case (ctl.mode)
      MODE_13BIT: begin
        if (step) begin
          next_low[4:0] = ctl.low[4:0] + 5'h01;
          if (ctl.low[4:0] == LOW13_MAX) begin
            next_high = ctl.high + 8'h01;
            next_ovf = (ctl.high == BYTE_MAX);
          end
        end
      end
      MODE_16BIT: begin
        if (step) begin
          {next_high, next_low} = {ctl.high, ctl.low} + 16'h0001;
          next_ovf = (ctl.high == BYTE_MAX) && (ctl.low == BYTE_MAX);
        end
      end
      MODE_RELOAD: begin
        if (step) begin // see RULE1
          if (ctl.low == BYTE_MAX) begin
            next_low = ctl.high; // see RULE2
            next_ovf = 1'b1; // see RULE2
          end else begin
            next_low = ctl.low + 8'h01;
          end
        end
      end
      default: begin
        // The second timer simply holds in this mode.
        if (CAN_SPLIT) begin
          if (step) begin
            next_low = ctl.low + 8'h01;
            next_ovf = (ctl.low == BYTE_MAX);
          end
          if (ctl.splitRun && ctl.tick) begin
            next_high = ctl.high + 8'h01;
            next_hiOvf = (ctl.high == BYTE_MAX);
          end
        end
      end
    endcase
    // The reload byte is only ever written by software.
    if (ctl.wrLow) begin
      next_low = ctl.wdata; // see RULE15
    end
    if (ctl.wrHigh) begin
      next_high = ctl.wdata; // see RULE4
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl.low <= BYTE_RESET;
      ctl.high <= BYTE_RESET;
      ctl.ovf <= 1'b0;
      ctl.hiOvf <= 1'b0;
    end else begin
      ctl.low <= next_low;
      ctl.high <= next_high;
      ctl.ovf <= next_ovf;
      ctl.hiOvf <= next_hiOvf;
    end
  end
endmodule : dt_timer_unit

// ===== logic/dt_top.sv
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module dt_top (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [dt_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response.
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [dt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [dt_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // External pins.
  input wire logic firstCountPin,
  input wire logic secondCountPin,
  input wire logic firstExtIrqInput,
  input wire logic secondExtIrqInput,
  // Interrupt.
  output logic irq
);
  import dt_pkg::*;

  dt_ctl_if ctl0 ();
  dt_ctl_if ctl1 ();

  // Bus slave state.
  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] awAddr;
  logic [7:0] wData;
  logic wLane;
  logic [1:0] bresp;
  logic bvalid;
  logic rvalid;
  logic [7:0] rdata;
  logic [1:0] rresp;
  logic next_awHeld;
  logic next_wHeld;
  logic [ADDR_W-1:0] next_awAddr;
  logic [7:0] next_wData;
  logic next_wLane;
  logic [1:0] next_bresp;
  logic next_bvalid;
  logic next_rvalid;
  logic [7:0] next_rdata;
  logic [1:0] next_rresp;

  // Software registers.
  logic [7:0] timerPairMode;
  logic [1:0] timerControlReg;
  logic [1:0] extIrqConfigReg;
  logic [1:0] clockControlReg;
  logic [1:0] irqStatus;
  logic [1:0] irqEnable;
  logic [7:0] next_timerPairMode;
  logic [1:0] next_timerControlReg;
  logic [1:0] next_extIrqConfigReg;
  logic [1:0] next_clockControlReg;
  logic [1:0] next_irqStatus;
  logic [1:0] next_irqEnable;
  logic [1:0] clrBits;
  logic [1:0] setBits;

  // Pin sampling and prescaler.
  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  logic [3:0] pinPrev;
  logic [3:0] next_pinPrev;
  logic [3:0] presc;
  logic [3:0] next_presc;
  logic prescTick;
  logic doWrite;

  dt_timer_unit #(
    .CAN_SPLIT(1'b1)
  ) u_first (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ctl(ctl0.unit)
  );

  dt_timer_unit #(
    .CAN_SPLIT(1'b0)
  ) u_second (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ctl(ctl1.unit)
  );

  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = {24'h000000, rdata};
  assign s_axi_rresp = rresp;
  assign irq = |(irqStatus & irqEnable); // see RULE3

  // Pins: bit 0/1 count pins, bit 2/3 external interrupt inputs.
  always_comb begin
    next_pinPrev = pinSync;
    next_presc = (presc == PRESC_LAST) ? PRESC_RESET : presc + 4'h1;
    prescTick = (presc == PRESC_LAST);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= 4'h0;
      pinSync <= 4'h0;
      pinPrev <= 4'h0;
      presc <= PRESC_RESET;
    end else begin
      pinMeta <= {secondExtIrqInput, firstExtIrqInput,
        secondCountPin, firstCountPin}; // see RULE14
      pinSync <= pinMeta;
      pinPrev <= next_pinPrev;
      presc <= next_presc;
    end
  end

  // Falling edges come from two settled samples, never the first stage.
  assign ctl0.pinFall = pinPrev[0] && !pinSync[0]; // see RULE14
  assign ctl1.pinFall = pinPrev[1] && !pinSync[1]; // see RULE14
  assign ctl0.gateOn = extIrqConfigReg[0] ? pinSync[2] : !pinSync[2];
  assign ctl1.gateOn = extIrqConfigReg[1] ? pinSync[3] : !pinSync[3];
  assign ctl0.run = timerControlReg[RUN0_BIT]; // see RULE7
  assign ctl1.run = timerControlReg[RUN1_BIT]; // see RULE6
  assign ctl0.gateSel = timerPairMode[FIRST_GATE_SELECT_BIT]; // see RULE11
  assign ctl1.gateSel = timerPairMode[SECOND_GATE_SELECT_BIT]; // see RULE8
  assign ctl0.ctSel = timerPairMode[CT0_BIT]; // see RULE12
  assign ctl1.ctSel = timerPairMode[CT1_BIT]; // see RULE9
  assign ctl0.mode = timerPairMode[MODE0_LSB +: 2]; // see RULE13
  assign ctl1.mode = timerPairMode[MODE1_LSB +: 2]; // see RULE10
  assign ctl0.tick = clockControlReg[0] || prescTick;
  assign ctl1.tick = clockControlReg[1] || prescTick;
  // In split mode the first high byte borrows the second run bit.
  assign ctl0.splitRun = timerControlReg[RUN1_BIT];
  assign ctl1.splitRun = 1'b0;
  assign ctl0.wdata = wData;
  assign ctl1.wdata = wData;

  // The split high byte shares the second timer's flag.
  assign setBits = {ctl1.ovf || ctl0.hiOvf, ctl0.ovf};

  always_comb begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddr = awAddr;
    next_wData = wData;
    next_wLane = wLane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_timerPairMode = timerPairMode;
    next_timerControlReg = timerControlReg;
    next_extIrqConfigReg = extIrqConfigReg;
    next_clockControlReg = clockControlReg;
    next_irqEnable = irqEnable;
    clrBits = 2'h0;
    ctl0.wrLow = 1'b0;
    ctl0.wrHigh = 1'b0;
    ctl1.wrLow = 1'b0;
    ctl1.wrHigh = 1'b0;
    doWrite = awHeld && wHeld && !bvalid;
    if (s_axi_awvalid && !awHeld) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata[7:0];
      next_wLane = s_axi_wstrb[0];
    end
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (awAddr == OFF_MODE) begin
        if (wLane) next_timerPairMode = wData;
      end else if (awAddr == OFF_CTRL) begin
        if (wLane) next_timerControlReg = wData[1:0];
      end else if (awAddr == OFF_IRQCFG) begin
        if (wLane) next_extIrqConfigReg = wData[1:0];
      end else if (awAddr == OFF_CLKCTL) begin
        if (wLane) next_clockControlReg = wData[1:0];
      end else if (awAddr == OFF_FIRST_LOW) begin
        ctl0.wrLow = wLane; // see RULE5
      end else if (awAddr == OFF_FIRST_HIGH) begin
        ctl0.wrHigh = wLane;
      end else if (awAddr == OFF_SECOND_LOW) begin
        ctl1.wrLow = wLane;
      end else if (awAddr == OFF_SECOND_HIGH) begin
        ctl1.wrHigh = wLane;
      end else if (awAddr == OFF_STATUS) begin
        next_bresp = RESP_OKAY;
      end else if (awAddr == OFF_CLEAR) begin
        if (wLane) clrBits = wData[1:0];
      end else if (awAddr == OFF_ENABLE) begin
        if (wLane) next_irqEnable = wData[1:0];
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 8'h00;
      if (s_axi_araddr == OFF_MODE) begin
        next_rdata = timerPairMode;
      end else if (s_axi_araddr == OFF_CTRL) begin
        next_rdata = {6'h00, timerControlReg};
      end else if (s_axi_araddr == OFF_IRQCFG) begin
        next_rdata = {6'h00, extIrqConfigReg};
      end else if (s_axi_araddr == OFF_CLKCTL) begin
        next_rdata = {6'h00, clockControlReg};
      end else if (s_axi_araddr == OFF_FIRST_LOW) begin
        next_rdata = ctl0.low;
      end else if (s_axi_araddr == OFF_FIRST_HIGH) begin
        next_rdata = ctl0.high;
      end else if (s_axi_araddr == OFF_SECOND_LOW) begin
        next_rdata = ctl1.low;
      end else if (s_axi_araddr == OFF_SECOND_HIGH) begin
        next_rdata = ctl1.high;
      end else if (s_axi_araddr == OFF_STATUS) begin
        next_rdata = {6'h00, irqStatus};
      end else if (s_axi_araddr == OFF_CLEAR) begin
        next_rdata = 8'h00;
      end else if (s_axi_araddr == OFF_ENABLE) begin
        next_rdata = {6'h00, irqEnable};
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end
    // A new overflow in the clearing cycle keeps its flag.
    next_irqStatus = (irqStatus & ~clrBits) | setBits; // see RULE2
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= BYTE_RESET;
      wLane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= BYTE_RESET;
      rresp <= RESP_OKAY;
      timerPairMode <= BYTE_RESET;
      timerControlReg <= FLAG_RESET;
      extIrqConfigReg <= FLAG_RESET;
      clockControlReg <= FLAG_RESET;
      irqStatus <= FLAG_RESET;
      irqEnable <= FLAG_RESET;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wData <= next_wData;
      wLane <= next_wLane;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      timerPairMode <= next_timerPairMode;
      timerControlReg <= next_timerControlReg;
      extIrqConfigReg <= next_extIrqConfigReg;
      clockControlReg <= next_clockControlReg;
      irqStatus <= next_irqStatus;
      irqEnable <= next_irqEnable;
    end
  end
endmodule : dt_top
